// >>> core/ddr_pad_io_cell.v
/*
 * ddr_pad_io_cell.v: one programmable pad with direct, registered and
 * double-data-rate capture, a hold latch, registered or double-data-rate
 * launch with tristate control, and an optional clock buffer tap.
 * Assumes the capture and launch clocks and the pad arrive as pins slower
 * than clock_i, an APB master on clock_i, and a bank hold level from logic
 * on clock_i.
 */
`timescale 1ns/1ps
`include "pad_cell_defs.vh"

// Notes on behaviour
// - While the hold control is high the last sampled pad value is frozen; low lets it pass.
// - The hold control is one bank-wide input, not a per-pin setting.
// - One advance enable gates every flop and should be tied high when unused.
// - With the advance enable at 0 every flop keeps its value, at 1 flops load on their edge.
// - Input flops of the registered modes advance only on edges of the capture clock, which idles low when unused.
// - Output flops, except in the every-clock kind and the enable cleared while output is off, advance only on launch clock edges; that clock idles low.
// - The pad is driven when the drive enable is 1 and released when it is 0.
// - In double-rate output the first bit goes to the pad on the launch rising edge.
// - In double-rate output the second bit goes to the pad on the launch falling edge.
// - In double-rate input the first received output holds the pad sampled at capture rise.
// - In double-rate input the second received output holds the pad sampled at capture fall.
// - The clock buffer variant keeps every pad port and adds a direct clock buffer tap.
// - Only clock buffer seven of eight takes a differential clock from the bank-three pair.
// - The six-bit type word has an output field in bits 5..2 and an input field in 1..0.
// - With clock inversion set the rising and falling roles of both clocks swap.
module ddr_pad_io_cell #(
   parameter CLKBUF_VARIANT = 0,
   parameter [2:0] CLKBUF_INDEX = 3'h0
) (
   // clock, reset and advance enable
   input  wire        clock_i,
   input  wire        rst_b_i,
   input  wire        ce_i,
   // apb slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // package pins and pin clocks
   input  wire        diff_pair_true_pin_i,
   input  wire        diff_pair_comp_pin_i,
   input  wire        cap_clk_i,
   input  wire        launch_clk_i,
   output reg         pad_o,
   output reg         pad_oe_o,
   // bank-wide hold control
   input  wire        hold_bank_i,
   // received data and clock buffer tap
   output reg         d_in_0_o,
   output reg         d_in_1_o,
   output reg         clkbuf_o
);

   // configuration
   reg  [8:0]  cfg_q;
   wire [3:0]  out_f   = cfg_q[`CFG_OUT_HI:`CFG_OUT_LO];
   wire [1:0]  in_f    = cfg_q[`CFG_IN_HI:`CFG_IN_LO];
   wire        inv     = cfg_q[`CFG_INV_BIT];
   wire        diff_rx = cfg_q[`CFG_DIFF_BIT];
   wire        in_ddr  = cfg_q[`CFG_INDDR_BIT];

   // pin synchronisers: three flops, a change counts when the last two agree
   wire [`SYNC_PINS-1:0] pins_raw = {launch_clk_i, cap_clk_i,
                                      diff_pair_comp_pin_i, diff_pair_true_pin_i};
   reg  [`SYNC_PINS-1:0] s1_q;
   reg  [`SYNC_PINS-1:0] s2_q;
   reg  [`SYNC_PINS-1:0] s3_q;
   reg  [`SYNC_PINS-1:0] pin_q;
   reg  [`SYNC_PINS-1:0] pin_prev_q;
   genvar g;

   generate
      for (g = 0; g < `SYNC_PINS; g = g + 1) begin : g_sync
         always @(posedge clock_i) begin
            if (!rst_b_i) begin
               s1_q[g]       <= 1'b0;
               s2_q[g]       <= 1'b0;
               s3_q[g]       <= 1'b0;
               pin_q[g]      <= 1'b0;
               pin_prev_q[g] <= 1'b0;
            end else if (ce_i) begin
               s1_q[g]       <= pins_raw[g];
               s2_q[g]       <= s1_q[g];
               s3_q[g]       <= s2_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  pin_q[g] <= s3_q[g];
               end
               pin_prev_q[g] <= pin_q[g];
            end
         end
      end
   endgenerate

   wire pad_true = pin_q[0];
   wire pad_comp = pin_q[1];
   wire cap_up   = pin_q[2] & ~pin_prev_q[2];
   wire cap_dn   = ~pin_q[2] & pin_prev_q[2];
   wire lau_up   = pin_q[3] & ~pin_prev_q[3];
   wire lau_dn   = ~pin_q[3] & pin_prev_q[3];

   // inversion swaps which pin edge acts as rising
   wire cap_rise = inv ? cap_dn : cap_up;
   wire cap_fall = inv ? cap_up : cap_dn;
   wire lau_rise = inv ? lau_dn : lau_up;
   wire lau_fall = inv ? lau_up : lau_dn;

   // receiver: differential resolves only when the pair disagrees,
   // an equal pair is no valid level so the last one is kept
   reg  rx_q;
   wire rx_val = diff_rx ? ((pad_true != pad_comp) ? pad_true : rx_q)
                         : pad_true;

   // hold latch sits before every capture flop
   reg  held_q;
   wire pad_in = hold_bank_i ? held_q : rx_val;

   // transmit queue
   wire                 q_in_ready;
   wire                 q_out_valid;
   wire [`TX_WIDTH-1:0] q_head;
   wire [`TXQ_AW:0]     q_level;
   reg                  q_push;
   reg                  q_pop;

   // apb decode
   wire setup_ok = psel_i & penable_i & ~pready_o;
   wire a_cfg    = (paddr_i == `OFF_CFG);
   wire a_tx     = (paddr_i == `OFF_TXDATA);
   wire a_rx     = (paddr_i == `OFF_RXDATA);
   wire a_st     = (paddr_i == `OFF_STATUS);
   wire mapped   = a_cfg | a_tx | a_rx | a_st;
   // a queued write waits in the access phase while the queue is full
   wire can_ans  = ~(pwrite_i & a_tx & ~q_in_ready);
   wire done     = psel_i & penable_i & pready_o;

   always @* begin
      q_push = done & pwrite_i & a_tx & ~pslverr_o;
   end

   tx_queue #(
      .WIDTH (`TX_WIDTH),
      .DEPTH (`TXQ_DEPTH),
      .AW    (`TXQ_AW)
   ) u_txq (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .ce_i        (ce_i),
      .in_valid_i  (q_push),
      .in_ready_o  (q_in_ready),
      .in_data_i   (pwdata_i[`TX_WIDTH-1:0]),
      .out_valid_o (q_out_valid),
      .out_ready_i (q_pop),
      .out_data_o  (q_head),
      .level_o     (q_level)
   );

   // output kind decode of the upper field
   wire [1:0] kind    = out_f[1:0];
   wire [1:0] en_mode = out_f[3:2];
   wire       out_off = (out_f == `OUT_NONE);
   wire       is_ddr  = ~out_off & (kind == `OUT_KIND_DDR);
   wire       is_comb = (kind == `OUT_KIND_COMB);

   // the unregistered kind follows the queue every cycle, the rest on launch rise
   always @* begin
      q_pop = q_out_valid & ~out_off & (is_comb | lau_rise);
   end

   wire d0_w = q_head[`TX_D0_BIT];
   wire d1_w = q_head[`TX_D1_BIT];
   wire oe_w = q_head[`TX_OE_BIT];
   reg  d1_q;

   // apb, configuration and readback
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         cfg_q     <= `CFG_RESET;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else if (ce_i) begin
         if (setup_ok && can_ans) begin
            pready_o  <= 1'b1;
            pslverr_o <= ~mapped;
            prdata_o  <= 32'h00000000;
            if (!pwrite_i) begin
               if (a_cfg) begin
                  prdata_o <= {23'h000000, cfg_q};
               end else if (a_rx) begin
                  prdata_o <= {29'h00000000, rx_q, d_in_1_o, d_in_0_o};
               end else if (a_st) begin
                  prdata_o <= {22'h000000, q_level, ~q_in_ready,
                               ~q_out_valid, hold_bank_i, pad_oe_o};
               end
            end
         end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
         end
         if (done && pwrite_i && a_cfg) begin
            cfg_q <= pwdata_i[8:0];
         end
      end
   end

   // input path
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         rx_q     <= 1'b0;
         held_q   <= 1'b0;
         d_in_0_o <= 1'b0;
         d_in_1_o <= 1'b0;
         clkbuf_o <= 1'b0;
      end else if (ce_i) begin
         rx_q   <= rx_val;
         held_q <= pad_in;
         case (in_f)
            `IN_DIRECT, `IN_LATCH: begin
               d_in_0_o <= pad_in;
            end
            `IN_REG_DDR, `IN_REG_LATCH: begin
               if (cap_rise) begin
                  d_in_0_o <= pad_in;
               end
               if (cap_fall && in_ddr) begin
                  d_in_1_o <= pad_in;
               end
            end
            default: begin
               d_in_0_o <= d_in_0_o;
            end
         endcase
         // tap bypasses the capture flops; only index seven may take a pair
         if (CLKBUF_VARIANT != 0) begin
            if (diff_rx && (CLKBUF_INDEX == `DIFF_CLKBUF_IDX)) begin
               clkbuf_o <= pad_in;
            end else begin
               clkbuf_o <= hold_bank_i ? held_q : pad_true;
            end
         end
      end
   end

   // output path
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         pad_o    <= 1'b0;
         pad_oe_o <= 1'b0;
         d1_q     <= 1'b0;
      end else if (ce_i) begin
         if (out_off) begin
            pad_oe_o <= 1'b0;
         end else if (q_pop) begin
            case (kind)
               `OUT_KIND_DDR: begin
                  pad_o <= d0_w;
                  d1_q  <= d1_w;
               end
               `OUT_KIND_INV: begin
                  pad_o <= ~d0_w;
               end
               default: begin
                  pad_o <= d0_w;
               end
            endcase
            case (en_mode)
               `OUT_EN_ALWAYS: pad_oe_o <= 1'b1;
               default:        pad_oe_o <= oe_w;
            endcase
         end else if (is_ddr && lau_fall) begin
            pad_o <= d1_q;
         end
      end
   end

endmodule // ddr_pad_io_cell

// >>> pkg/pad_cell_defs.vh
/*
 * pad_cell_defs.vh: register offsets, field positions, reset values and
 * sizes shared by the pad cell and its transmit queue.
 * Assumes an APB master with 32-bit data and word-aligned byte addresses.
 */
`ifndef PAD_CELL_DEFS_VH
`define PAD_CELL_DEFS_VH

// register byte offsets
`define OFF_CFG          8'h00
`define OFF_TXDATA       8'h04
`define OFF_RXDATA       8'h08
`define OFF_STATUS       8'h0C

// configuration register fields
`define CFG_TYPE_HI      5
`define CFG_TYPE_LO      0
`define CFG_OUT_HI       5
`define CFG_OUT_LO       2
`define CFG_IN_HI        1
`define CFG_IN_LO        0
`define CFG_INV_BIT      6
`define CFG_DIFF_BIT     7
`define CFG_INDDR_BIT    8
`define CFG_RESET        9'h000

// transmit word fields
`define TX_D0_BIT        0
`define TX_D1_BIT        1
`define TX_OE_BIT        2
`define TX_WIDTH         3

// transmit queue depth and its pointer width
`define TXQ_DEPTH        32
`define TXQ_AW           5

// output structure codes (upper field)
`define OUT_NONE         4'h0
`define OUT_EN_ALWAYS    2'h1
`define OUT_EN_DIRECT    2'h2
`define OUT_EN_REG       2'h3
`define OUT_KIND_DDR     2'h0
`define OUT_KIND_REG     2'h1
`define OUT_KIND_COMB    2'h2
`define OUT_KIND_INV     2'h3

// input structure codes (lower field)
`define IN_REG_DDR       2'h0
`define IN_DIRECT        2'h1
`define IN_REG_LATCH     2'h2
`define IN_LATCH         2'h3

// pin synchroniser and clock buffer index that takes a differential clock
`define SYNC_PINS        4
`define DIFF_CLKBUF_IDX  3'h7

`endif

// >>> core/tx_queue.v
/*
 * tx_queue.v: first-in first-out store for outgoing pad words, with
 * valid/ready on both sides and registered read data.
 * Assumes one clock, a synchronous active-low reset and a clock enable
 * that freezes all state.
 */
`timescale 1ns/1ps

module tx_queue #(
   parameter WIDTH = 3,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   // clock and reset
   input  wire             clock_i,
   input  wire             rst_b_i,
   input  wire             ce_i,
   // fill side
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   // drain side
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   // fill level
   output wire [AW:0]      level_o
);

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_q;
   reg  [AW-1:0]    rd_q;
   reg  [AW:0]      cnt_q;
   reg  [WIDTH-1:0] head_q;
   wire             push;
   wire             pop;
   wire [AW-1:0]    rd_d;

   assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o  = head_q;
   assign level_o     = cnt_q;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign rd_d        = pop ? rd_q + {{(AW-1){1'b0}}, 1'b1} : rd_q;

   always @(posedge clock_i) begin
      if (ce_i && push) begin
         mem[wr_q] <= in_data_i;
      end
   end

   // head register looks one slot ahead so read data always leave a flop
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         wr_q   <= {AW{1'b0}};
         rd_q   <= {AW{1'b0}};
         cnt_q  <= {(AW+1){1'b0}};
         head_q <= {WIDTH{1'b0}};
      end else if (ce_i) begin
         if (push) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         rd_q  <= rd_d;
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
         if (push && (wr_q == rd_d)) begin
            head_q <= in_data_i;
         end else begin
            head_q <= mem[rd_d];
         end
      end
   end

endmodule // tx_queue

// >>> tb/ddr_pad_io_cell_chk.sv
/* checker: apb handshake and register-advance freeze of the pad cell.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module ddr_pad_io_cell_chk (
   // clock, reset, advance enable
   input wire        clock_i,
   input wire        rst_b_i,
   input wire        ce_i,
   // apb
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   // pad side
   input wire        pad_o,
   input wire        pad_oe_o,
   input wire        d_in_0_o,
   input wire        d_in_1_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   ready_pulse_a: assert property (pready_o && ce_i |=> !pready_o)
      else $error("pready longer than one cycle");
   ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
      else $error("pready without access phase");
   setup_wait_a: assert property ($rose(psel_i) |=> !pready_o)
      else $error("pready in setup cycle");
   err_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   unmapped_err_a: assert property (pready_o && paddr_i[7:4] != 4'h0 |-> pslverr_o)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready_o && paddr_i[7:4] == 4'h0 && paddr_i[1:0] == 2'h0
                                 |-> !pslverr_o)
      else $error("mapped access refused");
   err_data_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("refused read returned data");
   flops_frozen_a: assert property (!ce_i |=> $stable(pad_o) && $stable(pad_oe_o)
                                    && $stable(d_in_0_o) && $stable(d_in_1_o))
      else $error("flop moved with advance enable low");
endmodule // ddr_pad_io_cell_chk

bind ddr_pad_io_cell ddr_pad_io_cell_chk i_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
   .d_in_0_o(d_in_0_o), .d_in_1_o(d_in_1_o));

// >>> tb/pad_far_side.sv
/* far side of the pad: the package pin pair and the two pin clocks.
   assumes its tasks are called right after a rising clock_i edge. */
`timescale 1ns/1ps
module pad_far_side (
   // system clock
   input  wire clock_i,
   // cell drive and board level
   input  wire pad_i,
   input  wire pad_oe_i,
   input  wire ext_level_i,
   // pins and pin clocks
   output wire true_pin_o,
   output wire comp_pin_o,
   output reg  cap_clk_o,
   output reg  launch_clk_o
);
   // pin shows the cell while it drives, else the board level
   assign true_pin_o = pad_oe_i ? pad_i : ext_level_i;
   assign comp_pin_o = ~true_pin_o;
   // pin clocks stand low outside frames
   initial begin
      cap_clk_o = 1'b0;
      launch_clk_o = 1'b0;
   end
   // 12-clock half periods stay well under the pin sampling limit
   task cap_edge;
      begin
         cap_clk_o <= ~cap_clk_o;
         repeat (12) @(posedge clock_i);
      end
   endtask
   task launch_edge;
      begin
         launch_clk_o <= ~launch_clk_o;
         repeat (12) @(posedge clock_i);
      end
   endtask
endmodule // pad_far_side

// >>> tb/ddr_pad_io_cell_test.sv
/* bench for the pad cell: apb master, capture model and queue model.
   assumes the cell, its queue and the far side model are compiled. */
`timescale 1ns/1ps
`include "pad_cell_defs.vh"
module ddr_pad_io_cell_test;
   reg         clock_i, rst_b_i, ce_i, psel_i, penable_i, pwrite_i, hold_bank_i, ext;
   reg  [7:0]  paddr_i;
   reg  [31:0] pwdata_i, rd, cfg;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, pad_o, pad_oe_o, d_in_0_o, d_in_1_o, clkbuf_o;
   wire        tp, cp, cclk, lclk;
   integer     fails, checked, seed, i, j, k;
   reg         er, e0, e1;
   reg  [2:0]  w, w2;
   reg  [2:0]  txq [$];

   ddr_pad_io_cell #(.CLKBUF_VARIANT(1), .CLKBUF_INDEX(`DIFF_CLKBUF_IDX)) i_dut (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .diff_pair_true_pin_i(tp), .diff_pair_comp_pin_i(cp), .cap_clk_i(cclk),
      .launch_clk_i(lclk), .pad_o(pad_o), .pad_oe_o(pad_oe_o), .hold_bank_i(hold_bank_i),
      .d_in_0_o(d_in_0_o), .d_in_1_o(d_in_1_o), .clkbuf_o(clkbuf_o));
   pad_far_side i_far (.clock_i(clock_i), .pad_i(pad_o), .pad_oe_i(pad_oe_o),
      .ext_level_i(ext), .true_pin_o(tp), .comp_pin_o(cp), .cap_clk_o(cclk),
      .launch_clk_o(lclk));

   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   task check(input [31:0] seen, input [31:0] exp, input string what);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask

   // no cycle limit here: a hung slave is left to the watchdog
   task apb(input wr, input [7:0] a, input [31:0] d);
      begin
         @(posedge clock_i);
         psel_i <= 1'b1;
         pwrite_i <= wr;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge clock_i);
         penable_i <= 1'b1;
         @(posedge clock_i);
         while (pready_o !== 1'b1) begin
            @(posedge clock_i);
         end
         rd = prdata_o;
         er = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask

   task print_verdict;
      begin
         $display("checked %0d fails %0d", checked, fails);
         if (fails == 0 && checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // one launch edge; the queue model pops at rise
   task launch;
      begin
         i_far.launch_edge;
         if (lclk) begin
            w = txq.pop_front();
            check(pad_o, w[0], "pad at rise");
            check(pad_oe_o, w[2], "drive enable");
         end else
            check(pad_o, w[1], "pad at fall");
      end
   endtask

   initial begin
      #100000;
      fails = fails + 1;
      print_verdict;
   end

   initial begin
      seed = 32'h429B;
      fails = 0;
      checked = 0;
      {rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, hold_bank_i, ext} = 0;
      {e0, e1} = 2'b00;
      ce_i = 1'b1;
      repeat (10) @(posedge clock_i);
      rst_b_i <= 1'b1;
      apb(0, `OFF_CFG, 0);
      check(rd, `CFG_RESET, "cfg reset");
      apb(0, `OFF_STATUS, 0);
      check(rd, 32'h4, "status reset");
      apb(0, 8'h10, 0);
      check(er, 1'b1, "unmapped error");
      check(rd, 32'h0, "unmapped read");
      ce_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      ce_i <= 1'b1;
      // double rate, inverted and single rate capture, all on the diff receiver
      for (i = 0; i < 3; i = i + 1) begin
         cfg = (i == 0) ? 32'h180 : (i == 1) ? 32'h1C0 : 32'h080;
         apb(1, `OFF_CFG, cfg);
         apb(0, `OFF_CFG, 0);
         check(rd, cfg, "cfg readback");
         for (j = 0; j < 8; j = j + 1) begin
            k = $random(seed);
            ext <= k[0];
            repeat (8) @(posedge clock_i);
            i_far.cap_edge;
            if (cclk ^ cfg[6]) e0 = k[0];
            else if (cfg[8]) e1 = k[0];
            check(d_in_0_o, e0, "first received");
            check(d_in_1_o, e1, "second received");
         end
         apb(0, `OFF_RXDATA, 0);
         check(rd, {29'h0, ext, e1, e0}, "rx register");
      end
      // hold freezes the pad value and the clock buffer tap
      apb(1, `OFF_CFG, 32'h81);
      ext <= 1'b1;
      repeat (8) @(posedge clock_i);
      hold_bank_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      ext <= 1'b0;
      apb(0, `OFF_STATUS, 0);
      check(rd[1], 1'b1, "hold status");
      repeat (8) @(posedge clock_i);
      check(d_in_0_o, 1'b1, "held input");
      check(clkbuf_o, 1'b1, "held tap");
      hold_bank_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      check(d_in_0_o, 1'b0, "released input");
      check(clkbuf_o, 1'b0, "tap follows pad");
      // double rate launch, enable from word; fill to refusal, then drain
      apb(1, `OFF_CFG, 32'h30);
      for (i = 0; i < 32; i = i + 1) begin
         k = $random(seed);
         txq.push_back(k[2:0]);
         apb(1, `OFF_TXDATA, {29'h0, k[2:0]});
      end
      apb(0, `OFF_STATUS, 0);
      check(rd, 32'h208, "queue full");
      k = $random(seed);
      w2 = k[2:0];
      fork
         apb(1, `OFF_TXDATA, {29'h0, w2});
         begin
            repeat (20) @(posedge clock_i);
            check({psel_i, pready_o}, 2'b10, "write stalled");
            launch;
         end
      join
      txq.push_back(w2);
      for (i = 0; i < 65; i = i + 1)
         launch;
      apb(0, `OFF_STATUS, 0);
      check(rd, {31'h2, w[2]}, "queue drained");
      // registered inverted launch and the every-clock kind, enable forced on
      apb(1, `OFF_CFG, 32'h1C);
      k = $random(seed);
      apb(1, `OFF_TXDATA, {29'h0, k[2:0]});
      i_far.launch_edge;
      check(pad_o, !k[0], "inverted pad");
      check(pad_oe_o, 1'b1, "forced enable");
      apb(1, `OFF_CFG, 32'h18);
      apb(1, `OFF_TXDATA, {29'h0, k[2:0] ^ 3'h1});
      repeat (3) @(posedge clock_i);
      check(pad_o, !k[0], "every-clock pad");
      print_verdict;
   end
endmodule // ddr_pad_io_cell_test
